// File: shared/cise_pkg.sv
// Constants and types shared by the instruction subset executor
package cise_pkg;

	localparam int APB_AW  = 8;
	localparam int APB_DW  = 32;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int BANK_W  = 5;
	localparam int LATCH_W = 7;
	localparam int PC_W    = 15;
	localparam int PTR_W   = 16;
	localparam int OFS_W   = 6;
	localparam int INSTR_W = 22;

	// Register byte offsets
	localparam logic [APB_AW-1:0] OFS_INSTR  = 8'h00;
	localparam logic [APB_AW-1:0] OFS_ACC    = 8'h04;
	localparam logic [APB_AW-1:0] OFS_LATCH  = 8'h08;
	localparam logic [APB_AW-1:0] OFS_PTR0   = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_PTR1   = 8'h10;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;
	localparam logic [APB_AW-1:0] OFS_PC     = 8'h18;
	localparam logic [APB_AW-1:0] OFS_STACK  = 8'h1C;
	localparam logic [APB_AW-1:0] OFS_WDOG   = 8'h20;
	localparam logic [APB_AW-1:0] OFS_BANK   = 8'h24;
	localparam logic [APB_AW-1:0] OFS_MADDR  = 8'h28;
	localparam logic [APB_AW-1:0] OFS_MDATA  = 8'h2C;

	// Status register bit positions
	localparam int STAT_ZERO_BIT    = 0;
	localparam int STAT_SLEEP_BIT   = 1;
	localparam int STAT_EXPIRED_BIT = 2;
	localparam int STAT_BUSY_BIT    = 8;

	// Reset values of the status flags
	localparam logic RST_ZERO    = 1'b0;
	localparam logic RST_SLEEP   = 1'b1;
	localparam logic RST_EXPIRED = 1'b1;

	// File addresses of the two indirect windows
	localparam logic [FADDR_W-1:0] WIN0_FADDR = 7'h00;
	localparam logic [FADDR_W-1:0] WIN1_FADDR = 7'h01;

	// Pointer update mode fields
	localparam int MODE_DEC_BIT  = 0;
	localparam int MODE_POST_BIT = 1;

	typedef enum logic [3:0] {
		op_none                 = 4'h0,
		op_kick_watchdog        = 4'h1,
		op_call_via_accumulator = 4'h2,
		op_invert_file          = 4'h3,
		op_decrement_file       = 4'h4,
		op_zero_file            = 4'h5,
		op_zero_accumulator     = 4'h6,
		op_load_indirect        = 4'h7
	} cise_op_type;

	typedef struct packed {
		logic [OFS_W-1:0]   offset;
		logic               rel;
		logic [1:0]         pointer_update_mode;
		logic               sel;
		logic               dest;
		logic [FADDR_W-1:0] faddr;
		cise_op_type        op;
	} cise_instr_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_FETCH = 3'h2,
		ST_EXEC  = 3'h4
	} cise_state_type;

	typedef struct packed {
		logic [APB_AW-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_DW-1:0] pwdata;
	} cise_apb_req_type;

	typedef struct packed {
		logic [APB_DW-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} cise_apb_rsp_type;

endpackage

// File: rtl/cise_ptr_unit.sv
// Pointer address and update arithmetic for indirect loads
`timescale 1ns/1ps
`default_nettype none

module cise_ptr_unit (
	// Pointer and instruction fields
	input  wire logic [15:0] ptr_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic        rel_in,
	input  wire logic [5:0]  offset_in,
	// Results
	output logic      [15:0] eff_addr_out,
	output logic      [15:0] ptr_next_out
);
	logic [15:0] step;

	always_comb begin
		// Odd modes step down, upper mode bit defers the step
		step = mode_in[cise_pkg::MODE_DEC_BIT] ? 16'hFFFF : 16'h0001;
		if (rel_in) begin
			eff_addr_out = ptr_in + {{10{offset_in[5]}}, offset_in};
			ptr_next_out = ptr_in;
		end else begin
			// Plain 16-bit sum wraps both ways
			ptr_next_out = ptr_in + step;
			eff_addr_out = mode_in[cise_pkg::MODE_POST_BIT] ?
				ptr_in : ptr_next_out;
		end
	end
endmodule // cise_ptr_unit

`default_nettype wire

// File: rtl/cise_data_mem.sv
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module cise_data_mem #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          clk_in,
	// Access port
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [DW-1:0] wr_data_in,
	output logic      [DW-1:0] rd_data_out
);
	logic [DW-1:0] mem_r [2**AW];
	logic [DW-1:0] rd_r;

	// Read during write returns the old byte
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_r[addr_in] <= wr_data_in;
		end
		rd_r <= mem_r[addr_in];
	end

	assign rd_data_out = rd_r;
endmodule // cise_data_mem

`default_nettype wire

// File: rtl/cise_exec.sv
// Instruction subset executor with APB register access
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module cise_exec #(
	parameter int MEM_AW = 9,
	parameter int WDOG_W = 8,
	parameter int PRE_W  = 8
) (
	// Clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        srst_in,
	// APB slave
	input  wire cise_pkg::cise_apb_req_type  apb_req_in,
	output var  cise_pkg::cise_apb_rsp_type  apb_rsp_out,
	// Core state
	output logic [cise_pkg::PC_W-1:0]        pc_out,
	output logic                             busy_out,
	output logic                             expired_out,
	output logic                             sleep_out
);
	if (MEM_AW < 1 || MEM_AW > cise_pkg::PTR_W) begin : g_bad_aw
		$error("MEM_AW must lie between 1 and 16");
	end
	if (WDOG_W < 1 || PRE_W < 1) begin : g_bad_wdog
		$error("Watchdog widths must be at least 1");
	end

	typedef struct packed {
		cise_pkg::cise_state_type             fsm;
		logic                                 busy;
		cise_pkg::cise_instr_type             instr;
		logic [cise_pkg::DATA_W-1:0]          acc;
		logic [cise_pkg::LATCH_W-1:0]         latch;
		logic [1:0][cise_pkg::PTR_W-1:0]      ptr;
		logic                                 zero;
		logic                                 sleep;
		logic                                 expired;
		logic [cise_pkg::PC_W-1:0]            pc;
		logic [cise_pkg::PC_W-1:0]            stack;
		logic [WDOG_W-1:0]                    wdog;
		logic [PRE_W-1:0]                     pre;
		logic [cise_pkg::BANK_W-1:0]          bank;
		logic [cise_pkg::PTR_W-1:0]           maddr;
		logic                                 pend;
		cise_pkg::cise_apb_rsp_type           rsp;
	} cise_regs_type;

	cise_regs_type s_r;
	cise_regs_type s_nxt;

	logic [15:0] file_addr;
	logic [15:0] eff_addr;
	logic [15:0] ptr_next;
	logic [15:0] sel_ptr;
	logic        mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [7:0]  mem_wd;
	logic [7:0]  mem_rd;
	logic [7:0]  res;
	logic        done;
	logic [31:0] stat_word;

	assign sel_ptr = s_r.ptr[s_r.instr.sel];

	// Window addresses resolve to a pointer, others to bank plus offset
	always_comb begin
		if (s_r.instr.faddr == cise_pkg::WIN0_FADDR) begin
			file_addr = s_r.ptr[0];
		end else if (s_r.instr.faddr == cise_pkg::WIN1_FADDR) begin
			file_addr = s_r.ptr[1];
		end else begin
			file_addr = {4'h0, s_r.bank, s_r.instr.faddr};
		end
	end

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[cise_pkg::STAT_ZERO_BIT]    = s_r.zero;
		stat_word[cise_pkg::STAT_SLEEP_BIT]   = s_r.sleep;
		stat_word[cise_pkg::STAT_EXPIRED_BIT] = s_r.expired;
		stat_word[cise_pkg::STAT_BUSY_BIT]    = s_r.busy;
	end

	cise_ptr_unit u_ptr (
		.ptr_in       (sel_ptr),
		.mode_in      (s_r.instr.pointer_update_mode),
		.rel_in       (s_r.instr.rel),
		.offset_in    (s_r.instr.offset),
		.eff_addr_out (eff_addr),
		.ptr_next_out (ptr_next)
	);

	cise_data_mem #(
		.AW (MEM_AW),
		.DW (cise_pkg::DATA_W)
	) u_mem (
		.clk_in      (clk_in),
		.wr_en_in    (mem_we),
		.addr_in     (mem_addr),
		.wr_data_in  (mem_wd),
		.rd_data_out (mem_rd)
	);

	always_comb begin
		s_nxt = s_r;
		res = 8'h00;
		mem_we = 1'b0;
		mem_addr = s_r.maddr[MEM_AW-1:0];
		mem_wd = apb_req_in.pwdata[7:0];
		done = apb_req_in.psel && apb_req_in.penable && s_r.rsp.pready;
		s_nxt.rsp.pready = 1'b0;

		// Answers wait while an instruction runs, so the memory is free
		if (s_r.pend) begin
			s_nxt.pend = 1'b0;
			s_nxt.rsp.prdata = {24'h000000, mem_rd};
			s_nxt.rsp.pready = 1'b1;
		end else if (apb_req_in.psel && !s_r.rsp.pready && !s_r.busy) begin
			s_nxt.rsp.pready = 1'b1;
			s_nxt.rsp.pslverr = 1'b0;
			s_nxt.rsp.prdata = 32'h00000000;
			unique case (apb_req_in.paddr)
			cise_pkg::OFS_INSTR:  s_nxt.rsp.prdata = 32'(s_r.instr);
			cise_pkg::OFS_ACC:    s_nxt.rsp.prdata = 32'(s_r.acc);
			cise_pkg::OFS_LATCH:  s_nxt.rsp.prdata = 32'(s_r.latch);
			cise_pkg::OFS_PTR0:   s_nxt.rsp.prdata = 32'(s_r.ptr[0]);
			cise_pkg::OFS_PTR1:   s_nxt.rsp.prdata = 32'(s_r.ptr[1]);
			cise_pkg::OFS_STATUS: s_nxt.rsp.prdata = stat_word;
			cise_pkg::OFS_PC:     s_nxt.rsp.prdata = 32'(s_r.pc);
			cise_pkg::OFS_STACK:  s_nxt.rsp.prdata = 32'(s_r.stack);
			cise_pkg::OFS_WDOG:   s_nxt.rsp.prdata = 32'(s_r.wdog);
			cise_pkg::OFS_BANK:   s_nxt.rsp.prdata = 32'(s_r.bank);
			cise_pkg::OFS_MADDR:  s_nxt.rsp.prdata = 32'(s_r.maddr);
			cise_pkg::OFS_MDATA: begin
				// Memory read data needs one more cycle
				if (!apb_req_in.pwrite) begin
					s_nxt.pend = 1'b1;
					s_nxt.rsp.pready = 1'b0;
				end
			end
			default: s_nxt.rsp.pslverr = 1'b1;
			endcase
		end

		if (done && apb_req_in.pwrite) begin
			unique case (apb_req_in.paddr)
			cise_pkg::OFS_INSTR: begin
				s_nxt.instr = cise_pkg::cise_instr_type'(
					apb_req_in.pwdata[cise_pkg::INSTR_W-1:0]);
				s_nxt.fsm = cise_pkg::ST_FETCH;
			end
			cise_pkg::OFS_ACC:   s_nxt.acc = apb_req_in.pwdata[7:0];
			cise_pkg::OFS_LATCH: s_nxt.latch = apb_req_in.pwdata[6:0];
			cise_pkg::OFS_PTR0:  s_nxt.ptr[0] = apb_req_in.pwdata[15:0];
			cise_pkg::OFS_PTR1:  s_nxt.ptr[1] = apb_req_in.pwdata[15:0];
			cise_pkg::OFS_STATUS: begin
				s_nxt.zero = apb_req_in.pwdata[cise_pkg::STAT_ZERO_BIT];
				s_nxt.sleep = apb_req_in.pwdata[cise_pkg::STAT_SLEEP_BIT];
				s_nxt.expired =
					apb_req_in.pwdata[cise_pkg::STAT_EXPIRED_BIT];
			end
			cise_pkg::OFS_PC:    s_nxt.pc = apb_req_in.pwdata[14:0];
			cise_pkg::OFS_BANK:  s_nxt.bank = apb_req_in.pwdata[4:0];
			cise_pkg::OFS_MADDR: s_nxt.maddr = apb_req_in.pwdata[15:0];
			cise_pkg::OFS_MDATA: mem_we = 1'b1;
			default: ;
			endcase
		end

		// Timeout clears the flag after any software write, so it is kept
		s_nxt.pre = s_r.pre + 1'b1;
		if (&s_r.pre) begin
			s_nxt.wdog = s_r.wdog + 1'b1;
			if (&s_r.wdog) begin
				s_nxt.expired = 1'b0;
			end
		end

		unique case (s_r.fsm)
		cise_pkg::ST_IDLE: ;
		cise_pkg::ST_FETCH: begin
			s_nxt.fsm = cise_pkg::ST_IDLE;
			case (s_r.instr.op)
			cise_pkg::op_kick_watchdog: begin
				s_nxt.wdog = '0;
				s_nxt.pre = '0;
				s_nxt.expired = 1'b1;
				s_nxt.sleep = 1'b1;
			end
			cise_pkg::op_zero_accumulator: begin
				s_nxt.acc = 8'h00;
				s_nxt.zero = 1'b1;
			end
			cise_pkg::op_zero_file: begin
				mem_we = 1'b1;
				mem_addr = file_addr[MEM_AW-1:0];
				mem_wd = 8'h00;
				s_nxt.zero = 1'b1;
			end
			cise_pkg::op_call_via_accumulator: begin
				s_nxt.stack = s_r.pc + 15'h0001;
				s_nxt.fsm = cise_pkg::ST_EXEC;
			end
			cise_pkg::op_invert_file,
			cise_pkg::op_decrement_file: begin
				mem_addr = file_addr[MEM_AW-1:0];
				s_nxt.fsm = cise_pkg::ST_EXEC;
			end
			cise_pkg::op_load_indirect: begin
				mem_addr = eff_addr[MEM_AW-1:0];
				s_nxt.fsm = cise_pkg::ST_EXEC;
			end
			default: ;
			endcase
		end
		cise_pkg::ST_EXEC: begin
			s_nxt.fsm = cise_pkg::ST_IDLE;
			case (s_r.instr.op)
			cise_pkg::op_call_via_accumulator: begin
				s_nxt.pc = {s_r.latch, s_r.acc};
			end
			cise_pkg::op_invert_file,
			cise_pkg::op_decrement_file: begin
				if (s_r.instr.op == cise_pkg::op_invert_file) begin
					res = ~mem_rd;
				end else begin
					res = mem_rd - 8'h01;
				end
				if (s_r.instr.dest) begin
					mem_we = 1'b1;
					mem_addr = file_addr[MEM_AW-1:0];
					mem_wd = res;
				end else begin
					s_nxt.acc = res;
				end
				s_nxt.zero = (res == 8'h00);
			end
			cise_pkg::op_load_indirect: begin
				s_nxt.acc = mem_rd;
				s_nxt.zero = (mem_rd == 8'h00);
				s_nxt.ptr[s_r.instr.sel] = ptr_next;
			end
			default: ;
			endcase
		end
		endcase
		s_nxt.busy = (s_nxt.fsm != cise_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_r <= '0;
			s_r.fsm <= cise_pkg::ST_IDLE;
			s_r.zero <= cise_pkg::RST_ZERO;
			s_r.sleep <= cise_pkg::RST_SLEEP;
			s_r.expired <= cise_pkg::RST_EXPIRED;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp_out = s_r.rsp;
	assign pc_out = s_r.pc;
	assign busy_out = s_r.busy;
	assign expired_out = s_r.expired;
	assign sleep_out = s_r.sleep;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	logic fetch_r;
	logic exec_r;
	assign fetch_r = s_r.fsm == cise_pkg::ST_FETCH;
	assign exec_r = s_r.fsm == cise_pkg::ST_EXEC;

	chk_kick_restart: assert property (
		fetch_r && s_r.instr.op == cise_pkg::op_kick_watchdog |=>
		s_r.wdog == '0 && s_r.pre == '0 && s_r.expired && s_r.sleep)
		else $error("watchdog kick did not restart");
	chk_call_push: assert property (
		fetch_r && s_r.instr.op == cise_pkg::op_call_via_accumulator |=>
		s_r.stack == 15'($past(s_r.pc) + 15'h0001) && s_r.pc == $past(s_r.pc))
		else $error("call pushed a wrong return address");
	chk_call_target: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_call_via_accumulator |=>
		s_r.pc == {$past(s_r.latch), $past(s_r.acc)})
		else $error("call target wrong");
	chk_call_cycles: assert property (
		fetch_r && s_r.instr.op == cise_pkg::op_call_via_accumulator |=>
		exec_r && $stable(s_r.zero) ##1 !s_r.busy && $stable(s_r.zero))
		else $error("call not two cycles or flag touched");
	chk_invert_file: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_invert_file && s_r.instr.dest
		|-> mem_we && mem_wd == ~mem_rd ##1 s_r.zero == ($past(mem_wd) == 0))
		else $error("invert write-back wrong");
	chk_decrement_acc: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_decrement_file
		&& !s_r.instr.dest |=> s_r.acc == 8'($past(mem_rd) - 8'h01))
		else $error("decrement into accumulator wrong");
	chk_zero_file: assert property (
		fetch_r && s_r.instr.op == cise_pkg::op_zero_file |->
		mem_we && mem_wd == 8'h00 ##1 s_r.zero && !s_r.busy)
		else $error("zero-file wrong");
	chk_zero_acc: assert property (
		fetch_r && s_r.instr.op == cise_pkg::op_zero_accumulator |=>
		s_r.acc == 8'h00 && s_r.zero)
		else $error("zero-accumulator wrong");
	chk_load_zero: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_load_indirect |=>
		s_r.acc == $past(mem_rd) && s_r.zero == (s_r.acc == 8'h00))
		else $error("indirect load result wrong");
	chk_rel_ptr: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_load_indirect && s_r.instr.rel
		|=> s_r.ptr == $past(s_r.ptr))
		else $error("relative load moved the pointer");
	chk_post_inc: assert property (
		exec_r && s_r.instr.op == cise_pkg::op_load_indirect
		&& !s_r.instr.rel && s_r.instr.pointer_update_mode == 2'h2
		|=> s_r.ptr[$past(s_r.instr.sel)] == 16'($past(sel_ptr) + 16'h0001))
		else $error("post-increment pointer wrong");

	cov_kick: cover property (
		fetch_r && s_r.instr.op == cise_pkg::op_kick_watchdog);
	cov_call: cover property (
		exec_r && s_r.instr.op == cise_pkg::op_call_via_accumulator);
	cov_predec_wrap: cover property (
		exec_r && s_r.instr.op == cise_pkg::op_load_indirect
		&& sel_ptr == 16'h0000 && s_r.instr.pointer_update_mode == 2'h1);
endmodule // cise_exec

`default_nettype wire

// File: sim/cise_tb.sv
// Self-checking testbench for the instruction subset executor
`timescale 1ns/1ps
`default_nettype none

module testbench;

	logic                       clk_in;
	logic                       srst_in;
	cise_pkg::cise_apb_req_type req;
	cise_pkg::cise_apb_rsp_type rsp;
	logic [cise_pkg::PC_W-1:0]  pc;
	logic                       busy;
	logic                       expired;
	logic                       sleep;
	int                         err_count;
	int                         n_compared;
	int                         cycles;
	int                         i;
	logic [31:0]                seed;
	logic [31:0]                a;
	logic [31:0]                b;
	logic [31:0]                d;
	logic [31:0]                r;
	logic [15:0]                p;
	logic [15:0]                ea;
	logic [11:0]                fa;
	logic [6:0]                 f;
	logic [1:0]                 m;
	logic [5:0]                 k;
	logic                       e;

	cise_exec #(.MEM_AW(9), .WDOG_W(8), .PRE_W(8)) DUT (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.apb_req_in  (req),
		.apb_rsp_out (rsp),
		.pc_out      (pc),
		.busy_out    (busy),
		.expired_out (expired),
		.sleep_out   (sleep)
	);

	initial clk_in = 1'b0;
	always #50 clk_in = ~clk_in;

	// Hang guard, well above the expected run of under two thousand cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			results();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] ins(input logic [3:0] op,
		input logic [6:0] fi, input logic dd, input logic s,
		input logic [1:0] mm, input logic rl, input logic [5:0] kk);
		return {10'h000, kk, rl, mm, s, dd, fi, op};
	endfunction

	function automatic logic [15:0] eff(input logic [15:0] pp,
		input logic [1:0] mm, input logic rl, input logic [5:0] kk);
		if (rl) return pp + {{10{kk[5]}}, kk};
		if (mm[1]) return pp;
		return mm[0] ? pp - 16'h0001 : pp + 16'h0001;
	endfunction

	function automatic logic [15:0] after(input logic [15:0] pp,
		input logic [1:0] mm, input logic rl);
		if (rl) return pp;
		return mm[0] ? pp - 16'h0001 : pp + 16'h0001;
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask

	// Released one idle cycle before the next setup, never same step
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] q, output logic er);
		int n;
		@(posedge clk_in);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= ad;
		req.pwdata  <= wd;
		@(posedge clk_in);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready wait", 32'h1, 32'h0);
		q = rsp.prdata;
		er = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] q;
		logic        er;
		apb(1'b1, ad, wd, q, er);
	endtask

	task automatic rdc(input string nm, input logic [7:0] ad,
		input logic [31:0] ex);
		logic [31:0] q;
		logic        er;
		apb(1'b0, ad, 32'h0, q, er);
		chk(nm, ex, q);
	endtask

	task automatic run(input logic [31:0] op, input int cyc);
		int n;
		wr(cise_pkg::OFS_INSTR, op);
		@(posedge clk_in);
		n = 0;
		while (busy === 1'b1 && n < 10) begin
			n++;
			@(posedge clk_in);
		end
		chk("busy cycles", cyc, n);
	endtask

	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		seed = 32'h0000001B;
		req = '0;
		srst_in = 1'b1;
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		rdc("status reset", cise_pkg::OFS_STATUS, 32'h6);
		chk("expired reset", 32'h1, {31'h0, expired});
		chk("sleep reset", 32'h1, {31'h0, sleep});
		// Unmapped and unaligned places answer with an error
		apb(1'b0, 8'h30, 32'h0, d, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b0, 8'h05, 32'h0, d, e);
		chk("unaligned error", 32'h1, {31'h0, e});
		// Kick once the count has left zero, at a random prescaler phase
		wr(cise_pkg::OFS_STATUS, 32'h0);
		repeat (300 + rnd() % 200) @(posedge clk_in);
		run(ins(cise_pkg::op_kick_watchdog, 0, 0, 0, 0, 0, 0), 1);
		rdc("status kick", cise_pkg::OFS_STATUS, 32'h6);
		chk("expired port", 32'h1, {31'h0, expired});
		chk("sleep port", 32'h1, {31'h0, sleep});
		rdc("wdog kick", cise_pkg::OFS_WDOG, 32'h0);
		// Sampled a few cycles before a restarted prescaler would carry
		repeat (240) @(posedge clk_in);
		rdc("wdog later", cise_pkg::OFS_WDOG, 32'h0);
		for (i = 0; i < 4; i++) begin
			a = (i == 0) ? 32'hFF : rnd();
			b = (i == 0) ? 32'h7F : rnd();
			wr(cise_pkg::OFS_ACC, {24'h0, a[7:0]});
			wr(cise_pkg::OFS_LATCH, {25'h0, b[6:0]});
			wr(cise_pkg::OFS_STATUS, {29'h0, a[10:8]});
			apb(1'b0, cise_pkg::OFS_PC, 32'h0, d, e);
			run(ins(cise_pkg::op_call_via_accumulator, 0, 0, 0, 0, 0, 0), 2);
			chk("pc port", {17'h0, b[6:0], a[7:0]}, {17'h0, pc});
			rdc("stack", cise_pkg::OFS_STACK, (d + 1) & 32'h7FFF);
			rdc("flags call", cise_pkg::OFS_STATUS, {29'h0, a[10:8]});
		end
		for (i = 0; i < 12; i++) begin
			d = rnd() & 32'hFF;
			if (i < 2) d = (i == 0) ? 32'hFF : 32'h01;
			f = (i == 2) ? 7'h7F : 7'(2 + rnd() % 126);
			b = rnd();
			fa = {b[4:0], f};
			r = (i % 2 == 0) ? ~d & 32'hFF : (d - 1) & 32'hFF;
			a = rnd() & 32'hFF;
			wr(cise_pkg::OFS_BANK, {27'h0, b[4:0]});
			wr(cise_pkg::OFS_MADDR, {20'h0, fa});
			wr(cise_pkg::OFS_MDATA, d);
			wr(cise_pkg::OFS_ACC, a);
			wr(cise_pkg::OFS_STATUS, {31'h0, r != 0});
			run(ins((i % 2 == 0) ? cise_pkg::op_invert_file :
				cise_pkg::op_decrement_file, f, i[1], 0, 0, 0, 0), 2);
			rdc("acc", cise_pkg::OFS_ACC, i[1] ? a : r);
			wr(cise_pkg::OFS_MADDR, {20'h0, fa});
			rdc("file", cise_pkg::OFS_MDATA, i[1] ? r : d);
			rdc("zero", cise_pkg::OFS_STATUS, {31'h0, r == 0});
		end
		wr(cise_pkg::OFS_STATUS, 32'h0);
		run(ins(cise_pkg::op_zero_file, f, 0, 0, 0, 0, 0), 1);
		rdc("file zeroed", cise_pkg::OFS_MDATA, 32'h0);
		rdc("zero set", cise_pkg::OFS_STATUS, 32'h1);
		wr(cise_pkg::OFS_STATUS, 32'h0);
		run(ins(cise_pkg::op_zero_accumulator, 0, 0, 0, 0, 0, 0), 1);
		rdc("acc zeroed", cise_pkg::OFS_ACC, 32'h0);
		rdc("zero set", cise_pkg::OFS_STATUS, 32'h1);
		// Wrap corners sit on the first eight steps, one per mode, offset bounds later
		for (i = 0; i < 16; i++) begin
			m = i[2:1];
			p = rnd();
			if (i == 0 || i == 4) p = 16'hFFFF;
			if (i == 2 || i == 6) p = 16'h0000;
			k = (i == 8) ? 6'h20 : (i == 10) ? 6'h1F : 6'(rnd());
			d = (i == 5) ? 32'h0 : rnd() & 32'hFF;
			ea = eff(p, m, i[3], k);
			wr(i[0] ? cise_pkg::OFS_PTR1 : cise_pkg::OFS_PTR0, p);
			wr(cise_pkg::OFS_MADDR, ea);
			wr(cise_pkg::OFS_MDATA, d);
			wr(cise_pkg::OFS_STATUS, {31'h0, d != 0});
			run(ins(cise_pkg::op_load_indirect, 0, 0, i[0], m, i[3], k), 2);
			rdc("load", cise_pkg::OFS_ACC, d);
			rdc("ptr", i[0] ? cise_pkg::OFS_PTR1 : cise_pkg::OFS_PTR0,
				after(p, m, i[3]));
			rdc("zero", cise_pkg::OFS_STATUS, {31'h0, d == 0});
		end
		for (i = 0; i < 2; i++) begin
			p = rnd();
			d = rnd() & 32'hFF;
			wr(i[0] ? cise_pkg::OFS_PTR1 : cise_pkg::OFS_PTR0, p);
			wr(cise_pkg::OFS_MADDR, p);
			wr(cise_pkg::OFS_MDATA, d);
			wr(cise_pkg::OFS_BANK, 32'h0);
			run(ins(cise_pkg::op_invert_file, i[0] ? cise_pkg::WIN1_FADDR :
				cise_pkg::WIN0_FADDR, 1, 0, 0, 0, 0), 2);
			wr(cise_pkg::OFS_MADDR, p);
			rdc("window", cise_pkg::OFS_MDATA, ~d & 32'hFF);
			rdc("ptr kept", i[0] ? cise_pkg::OFS_PTR1 : cise_pkg::OFS_PTR0,
				p);
		end
		results();
	end

endmodule // testbench

`default_nettype wire
